// *** hw/cpsw_arith.sv ***
// Arithmetic flag computation for one reported operation.
module cpsw_arith
	import cpsw_pkg::*;
(
	input wire cpsw_alu_req_type req,
	output logic carry,
	output logic half,
	output logic ovf,
	output logic ovf_touch
);

	// Nine-bit sums and differences with incoming carry.
	logic cin;
	logic [8:0] sum;
	logic [4:0] nib_sum;
	logic [8:0] diff;
	logic [4:0] nib_diff;
	logic [15:0] product;
	logic [7:0] add_res;
	logic [7:0] sub_res;
	logic is_add;
	logic is_sub;
	logic add_ovf;
	logic sub_ovf;

	assign is_add = (req.op == CPSW_OP_ADD) || (req.op == CPSW_OP_ADD_WITH_CARRY);
	assign is_sub = (req.op == CPSW_OP_SUBTRACT_WITH_BORROW);
	// Plain add ignores the carry; the other two consume it.
	assign cin = (req.op == CPSW_OP_ADD) ? 1'b0 : req.carry_in;
	assign sum = {1'b0, req.operand_a} + {1'b0, req.operand_b} + {8'h00, cin};
	assign nib_sum = {1'b0, req.operand_a[3:0]} + {1'b0, req.operand_b[3:0]} + {4'h0, cin};
	assign diff = {1'b0, req.operand_a} - {1'b0, req.operand_b} - {8'h00, cin};
	assign nib_diff = {1'b0, req.operand_a[3:0]} - {1'b0, req.operand_b[3:0]} - {4'h0, cin};
	assign product = req.operand_a * req.operand_b;
	assign add_res = sum[7:0];
	assign sub_res = diff[7:0];
	// Sign change: like-signed inputs for add, unlike-signed for subtract, giving a result unlike operand a in sign.
	assign add_ovf = (req.operand_a[7] == req.operand_b[7]) && (add_res[7] != req.operand_a[7]);
	assign sub_ovf = (req.operand_a[7] != req.operand_b[7]) && (sub_res[7] != req.operand_a[7]);

	// Carry and half-carry only from add or subtract, cleared otherwise.
	assign carry = is_add ? sum[8] : (is_sub ? diff[8] : 1'b0);
	assign half = is_add ? nib_sum[4] : (is_sub ? nib_diff[4] : 1'b0);

	// Overflow cause per operation class.
	always_comb begin
		ovf = 1'b0;
		ovf_touch = 1'b1;
		unique case (req.op)
			CPSW_OP_ADD, CPSW_OP_ADD_WITH_CARRY: begin
				ovf = add_ovf;
			end
			CPSW_OP_SUBTRACT_WITH_BORROW: begin
				ovf = sub_ovf;
			end
			CPSW_OP_MUL: begin
				ovf = (product > CPSW_BYTE_MAX);
			end
			CPSW_OP_DIV: begin
				ovf = (req.operand_b == 8'h00);
			end
			default: begin
				// Other operations leave overflow alone.
				ovf_touch = 1'b0;
			end
		endcase
	end

endmodule : cpsw_arith

// *** hw/cpsw_parity.sv ***
// Parity calculation over the accumulator.
module cpsw_parity
	import cpsw_pkg::*;
#(
	parameter int WIDTH = 8
) (
	input wire logic [WIDTH-1:0] data,
	output logic odd
);

	// Refuse, while the design is elaborated, a width that has no bits to check.
	if (WIDTH < 1) begin : g_bad_width
		$error("cpsw_parity: WIDTH must be at least one");
	end

	// Odd count of ones gives a one.
	assign odd = ^data;

endmodule : cpsw_parity

// *** hw/cpsw_status_word.sv ***
// Status word of the core: arithmetic flags, user flags, bank select, parity.
// Contract
// - Carry set on carry or borrow, else cleared.
// - Half-carry set on nibble carry or borrow.
// - Bits five and one belong to software only.
// - Bank select picks register bank base address.
// - Overflow set on signed overflow of add/subtract.
// - Overflow set when product exceeds one byte.
// - Overflow set on divide by zero.
// - Overflow cleared otherwise by those five; others keep.
// - Parity bit shows odd accumulator ones count.
// - Word at 0xd0, bit-addressable, resets to zero.
module cpsw_status_word
	import cpsw_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst,
	input wire cpsw_alu_req_type alu_req,
	input wire cpsw_sfr_req_type sfr_req,
	input wire logic [7:0] accumulator,
	output logic [7:0] program_status_word,
	output logic carry_out_flag,
	output logic half_carry_flag,
	output logic signed_overflow_flag,
	output logic [1:0] bank_select,
	output logic [4:0] bank_base
);

	// Stored writable bits of the word; bit 0 of this register is unused.
	logic [7:0] word;
	// Parity of the accumulator, registered straight into bit 0 of the word output.
	logic [7:0] next_word;
	logic next_parity;
	// Flag results from the arithmetic helper.
	logic a_carry;
	logic a_half;
	logic a_ovf;
	logic a_ovf_touch;
	// Address decode for byte and bit access.
	logic hit;
	logic byte_wr;
	logic bit_wr;
	logic [7:0] bit_mask;
	logic [7:0] sw_word;
	logic [7:0] hw_word;
	// Independent multiply overflow reference for the assertion below.
	logic product_big;

	// Flag arithmetic for the reported operation.
	cpsw_arith u_arith (
		.req(alu_req),
		.carry(a_carry),
		.half(a_half),
		.ovf(a_ovf),
		.ovf_touch(a_ovf_touch)
	);

	// Parity of the accumulator.
	cpsw_parity #(
		.WIDTH(8)
	) u_parity (
		.data(accumulator),
		.odd(next_parity)
	);

	// The word answers at one address regardless of page.
	assign hit = (sfr_req.addr == CPSW_ADDR);
	assign byte_wr = hit && sfr_req.byte_write;
	assign bit_wr = hit && sfr_req.bit_write;
	assign bit_mask = 8'h01 << sfr_req.bit_index;

	// Hardware update on top of the stored word.
	always_comb begin
		hw_word = word;
		if (alu_req.valid && (alu_req.op != CPSW_OP_NONE)) begin
			// Every reported operation rewrites carry and half-carry.
			// Multiply, divide and the other class clear both.
			hw_word[CPSW_CARRY_BIT] = a_carry;
			hw_word[CPSW_HALF_BIT] = a_half;
			if (a_ovf_touch) begin
				hw_word[CPSW_OVF_BIT] = a_ovf;
			end
		end
	end

	// Software write overrides hardware for the same cycle, writable bits only.
	always_comb begin
		sw_word = hw_word;
		if (byte_wr) begin
			sw_word = (sfr_req.wdata & CPSW_WRITE_MASK) | (hw_word & ~CPSW_WRITE_MASK);
		end else if (bit_wr) begin
			if (sfr_req.bit_value) begin
				sw_word = hw_word | (bit_mask & CPSW_WRITE_MASK);
			end else begin
				sw_word = hw_word & ~(bit_mask & CPSW_WRITE_MASK);
			end
		end
		next_word = sw_word & CPSW_WRITE_MASK;
	end

	// Stored writable bits of the word.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			word <= CPSW_RESET;
		end else begin
			word <= next_word;
		end
	end

	// Registered view of the fields for the rest of the core.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			program_status_word <= CPSW_RESET;
			carry_out_flag <= 1'b0;
			half_carry_flag <= 1'b0;
			signed_overflow_flag <= 1'b0;
			bank_select <= 2'h0;
			bank_base <= 5'h00;
		end else begin
			program_status_word <= {next_word[7:1], next_parity};
			carry_out_flag <= next_word[CPSW_CARRY_BIT];
			half_carry_flag <= next_word[CPSW_HALF_BIT];
			signed_overflow_flag <= next_word[CPSW_OVF_BIT];
			bank_select <= next_word[CPSW_BANK_HI:CPSW_BANK_LO];
			// Bank base is eight times the bank number.
			bank_base <= {next_word[CPSW_BANK_HI:CPSW_BANK_LO], 3'h0};
		end
	end

	// Assertions guarding the flag behaviour.
	property p_carry_add;
		@(posedge ref_clk) disable iff (rst)
		alu_req.valid && alu_req.op == CPSW_OP_ADD && !hit
		|=> carry_out_flag == (({1'b0, $past(alu_req.operand_a)}
		+ {1'b0, $past(alu_req.operand_b)}) > 9'h0ff);
	endproperty
	a_carry_add: assert property (p_carry_add) else $error("carry after add wrong");
	// A nibble borrow happens when the low nibble of a is below that of b plus the borrow.
	property p_half_sub;
		@(posedge ref_clk) disable iff (rst)
		alu_req.valid && alu_req.op == CPSW_OP_SUBTRACT_WITH_BORROW && !hit
		|=> half_carry_flag == ({1'b0, $past(alu_req.operand_a[3:0])}
		< ({1'b0, $past(alu_req.operand_b[3:0])} + {4'h0, $past(alu_req.carry_in)}));
	endproperty
	a_half_sub: assert property (p_half_sub) else $error("half carry after subtract wrong");
	property p_user_hold;
		@(posedge ref_clk) disable iff (rst)
		!hit |=> program_status_word[5] == $past(word[5]) && program_status_word[1] == $past(word[1]);
	endproperty
	a_user_hold: assert property (p_user_hold) else $error("user flag changed by hardware");
	property p_bank;
		@(posedge ref_clk) disable iff (rst)
		bank_base == {bank_select, 3'h0} && program_status_word[4:3] == bank_select;
	endproperty
	a_bank: assert property (p_bank) else $error("bank base mismatch");
	property p_mul_ovf;
		@(posedge ref_clk) disable iff (rst)
		alu_req.valid && alu_req.op == CPSW_OP_MUL && !hit
		|=> signed_overflow_flag == ($past(product_big));
	endproperty
	a_mul_ovf: assert property (p_mul_ovf) else $error("multiply overflow wrong");
	assign product_big = (alu_req.operand_a * alu_req.operand_b) > 16'h00ff;
	// Multiply and divide are arithmetic too, so they leave carry and half-carry clear.
	property p_muldiv_carry;
		@(posedge ref_clk) disable iff (rst)
		alu_req.valid && (alu_req.op == CPSW_OP_MUL || alu_req.op == CPSW_OP_DIV) && !hit
		|=> !carry_out_flag && !half_carry_flag;
	endproperty
	a_muldiv_carry: assert property (p_muldiv_carry) else $error("carry kept by mul or div");
	property p_div_zero;
		@(posedge ref_clk) disable iff (rst)
		alu_req.valid && alu_req.op == CPSW_OP_DIV && alu_req.operand_b == 8'h00 && !hit
		|=> signed_overflow_flag;
	endproperty
	a_div_zero: assert property (p_div_zero) else $error("divide by zero not flagged");
	property p_ovf_keep;
		@(posedge ref_clk) disable iff (rst)
		!(alu_req.valid && a_ovf_touch) && !hit |=> $stable(signed_overflow_flag);
	endproperty
	a_ovf_keep: assert property (p_ovf_keep) else $error("overflow changed without cause");
	property p_parity;
		@(posedge ref_clk) disable iff (rst)
		1'b1 |=> program_status_word[0] == ^$past(accumulator);
	endproperty
	a_parity: assert property (p_parity) else $error("parity bit wrong");
	property p_parity_ro;
		@(posedge ref_clk) disable iff (rst)
		byte_wr |=> program_status_word[0] == ^$past(accumulator) && word[0] == 1'b0;
	endproperty
	a_parity_ro: assert property (p_parity_ro) else $error("parity bit took a write");
	property p_byte_write;
		@(posedge ref_clk) disable iff (rst)
		byte_wr |=> program_status_word[7:1] == $past(sfr_req.wdata[7:1]);
	endproperty
	a_byte_write: assert property (p_byte_write) else $error("byte write lost");

	// Main scenarios worth seeing.
	c_add_carry: cover property (@(posedge ref_clk) disable iff (rst)
		alu_req.valid && alu_req.op == CPSW_OP_ADD ##1 carry_out_flag);
	c_div_zero: cover property (@(posedge ref_clk) disable iff (rst)
		alu_req.valid && alu_req.op == CPSW_OP_DIV ##1 signed_overflow_flag);
	c_bit_write: cover property (@(posedge ref_clk) disable iff (rst) bit_wr ##1 bank_select == 2'h3);

endmodule : cpsw_status_word

// *** shared/cpsw_pkg.sv ***
// Package holding the status word layout, addresses, opcodes and carried structs.
package cpsw_pkg;

	// Special function address of the status word.
	localparam logic [7:0] CPSW_ADDR = 8'hd0;
	// Value of the status word after reset.
	localparam logic [7:0] CPSW_RESET = 8'h00;
	// Bit positions of the fields inside the word.
	localparam int CPSW_CARRY_BIT = 7;
	localparam int CPSW_HALF_BIT = 6;
	localparam int CPSW_USER0_BIT = 5;
	localparam int CPSW_BANK_HI = 4;
	localparam int CPSW_BANK_LO = 3;
	localparam int CPSW_OVF_BIT = 2;
	localparam int CPSW_USER1_BIT = 1;
	localparam int CPSW_PARITY_BIT = 0;
	// Bits that a software write may change; parity is read only.
	localparam logic [7:0] CPSW_WRITE_MASK = 8'hfe;
	// Largest product that still fits in one byte.
	localparam logic [15:0] CPSW_BYTE_MAX = 16'h00ff;
	// Width of one register bank in data memory.
	localparam logic [4:0] CPSW_BANK_SPAN = 5'h08;

	// Operation classes reported by the arithmetic unit.
	typedef enum logic [2:0] {
		CPSW_OP_NONE = 3'h0,
		CPSW_OP_ADD = 3'h1,
		CPSW_OP_ADD_WITH_CARRY = 3'h2,
		CPSW_OP_SUBTRACT_WITH_BORROW = 3'h3,
		CPSW_OP_MUL = 3'h4,
		CPSW_OP_DIV = 3'h5,
		CPSW_OP_OTHER_ARITH = 3'h6
	} cpsw_op_type;

	// Flag update request from the arithmetic unit, valid for one cycle.
	typedef struct packed {
		logic valid;
		cpsw_op_type op;
		logic [7:0] operand_a;
		logic [7:0] operand_b;
		logic carry_in;
	} cpsw_alu_req_type;

	// Special function register access from the core.
	typedef struct packed {
		logic byte_write;
		logic bit_write;
		logic [7:0] addr;
		logic [2:0] bit_index;
		logic [7:0] wdata;
		logic bit_value;
	} cpsw_sfr_req_type;

endpackage : cpsw_pkg

// *** verif/cpu_status_word_flags_bench.sv ***
// Self-checking bench for the status word: reset, ALU flags, software writes, parity.
module cpu_status_word_flags_bench
	import cpsw_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	logic ref_clk; // Core clock, 25 MHz.
	logic rst = 1'b1; // Asynchronous reset, held from time zero.
	cpsw_alu_req_type alu_req = '0; // Flag update from the arithmetic unit.
	cpsw_sfr_req_type sfr_req = '0; // Register write from the core.
	logic [7:0] accumulator = 8'h00; // Accumulator seen by the parity logic.
	logic [7:0] program_status_word;
	logic carry_out_flag;
	logic half_carry_flag;
	logic signed_overflow_flag;
	logic [1:0] bank_select;
	logic [4:0] bank_base;
	logic [7:0] exp_word; // Word expected after the latest edge.
	integer fails = 0; // Mismatches seen.
	integer checks_done = 0; // Comparisons made.
	integer seed = 32'h1ecea47c; // Fixed seed so runs repeat.
	logic [31:0] r; // Random draw for controls.
	logic [31:0] q; // Random draw for data.

	cpsw_status_word DUT (
		.ref_clk(ref_clk),
		.rst(rst),
		.alu_req(alu_req),
		.sfr_req(sfr_req),
		.accumulator(accumulator),
		.program_status_word(program_status_word),
		.carry_out_flag(carry_out_flag),
		.half_carry_flag(half_carry_flag),
		.signed_overflow_flag(signed_overflow_flag),
		.bank_select(bank_select),
		.bank_base(bank_base)
	);

	// Free-running clock with a 40 ns period.
	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end

	// Builds one valid arithmetic request.
	function automatic cpsw_alu_req_type mka(cpsw_op_type op, logic [7:0] a, logic [7:0] b,
		logic c);
		return '{valid: 1'b1, op: op, operand_a: a, operand_b: b, carry_in: c};
	endfunction : mka

	// Builds one register write request.
	function automatic cpsw_sfr_req_type mks(logic bw, logic tw, logic [7:0] ad, logic [2:0] ix,
		logic [7:0] wd, logic bv);
		return '{byte_write: bw, bit_write: tw, addr: ad, bit_index: ix, wdata: wd, bit_value: bv};
	endfunction : mks

	// Works out the next word from the current one and the inputs taken at an edge.
	function automatic logic [7:0] model(logic [7:0] w, cpsw_alu_req_type a,
		cpsw_sfr_req_type s, logic [7:0] acc);
		logic [8:0] sum;
		logic [4:0] nib;
		logic c;
		logic [7:0] n;
		n = w;
		c = (a.op == CPSW_OP_ADD) ? 1'b0 : a.carry_in;
		if (a.valid && (a.op == CPSW_OP_ADD || a.op == CPSW_OP_ADD_WITH_CARRY)) begin
			sum = {1'b0, a.operand_a} + {1'b0, a.operand_b} + c;
			nib = {1'b0, a.operand_a[3:0]} + {1'b0, a.operand_b[3:0]} + c;
			n[7] = sum[8];
			n[6] = nib[4];
			n[2] = (a.operand_a[7] == a.operand_b[7]) && (sum[7] != a.operand_a[7]);
		end else if (a.valid && a.op == CPSW_OP_SUBTRACT_WITH_BORROW) begin
			sum = {1'b0, a.operand_a} - {1'b0, a.operand_b} - c;
			nib = {1'b0, a.operand_a[3:0]} - {1'b0, a.operand_b[3:0]} - c;
			n[7] = sum[8];
			n[6] = nib[4];
			n[2] = (a.operand_a[7] != a.operand_b[7]) && (sum[7] != a.operand_a[7]);
		end else if (a.valid && a.op == CPSW_OP_MUL) begin
			n[7] = 1'b0;
			n[6] = 1'b0;
			n[2] = (16'(a.operand_a) * 16'(a.operand_b)) > CPSW_BYTE_MAX;
		end else if (a.valid && a.op == CPSW_OP_DIV) begin
			n[7] = 1'b0;
			n[6] = 1'b0;
			n[2] = (a.operand_b == 8'h00);
		end else if (a.valid && a.op == CPSW_OP_OTHER_ARITH) begin
			n[7] = 1'b0;
			n[6] = 1'b0;
		end
		// Software writes win over the arithmetic result on the bits they touch.
		if (s.addr == CPSW_ADDR && s.byte_write) begin
			n = (n & ~CPSW_WRITE_MASK) | (s.wdata & CPSW_WRITE_MASK);
		end else if (s.addr == CPSW_ADDR && s.bit_write && s.bit_index != 3'h0) begin
			n[s.bit_index] = s.bit_value;
		end
		n[0] = ^acc;
		return n;
	endfunction : model

	// Compares one value and reports a mismatch at once.
	task automatic chk(input logic [7:0] got, input logic [7:0] want, input string what);
		checks_done++;
		if (got !== want) begin
			fails++;
			$display("CHECK FAILED at %0t: %s got %h want %h", $time, what, got, want);
		end
	endtask : chk

	// Drives one cycle of requests, checks the previous edge, then predicts this one.
	task automatic cyc(input cpsw_alu_req_type a, input cpsw_sfr_req_type s,
		input logic [7:0] acc);
		@(posedge ref_clk);
		alu_req <= a;
		sfr_req <= s;
		accumulator <= acc;
		@(negedge ref_clk);
		chk(program_status_word, exp_word, "word");
		chk({7'h0, carry_out_flag}, {7'h0, exp_word[7]}, "carry");
		chk({7'h0, half_carry_flag}, {7'h0, exp_word[6]}, "half");
		chk({7'h0, signed_overflow_flag}, {7'h0, exp_word[2]}, "ovf");
		chk({6'h0, bank_select}, {6'h0, exp_word[4:3]}, "bank");
		chk({3'h0, bank_base}, {3'h0, exp_word[4:3], 3'h0}, "base");
		exp_word = model(exp_word, a, s, acc);
	endtask : cyc

	// Holds reset for eleven cycles with idle inputs and checks the cleared word after the tenth.
	task automatic do_reset;
		@(posedge ref_clk);
		rst <= 1'b1;
		alu_req <= '0;
		sfr_req <= '0;
		accumulator <= 8'h00;
		repeat (10) @(posedge ref_clk);
		@(negedge ref_clk);
		chk(program_status_word, CPSW_RESET, "reset word");
		@(posedge ref_clk);
		rst <= 1'b0;
		exp_word = CPSW_RESET;
	endtask : do_reset

	// Prints the counts and the verdict, then stops.
	task automatic end_sim;
		$display("checks %0d fails %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : end_sim

	// Cuts the run short if the sequence hangs.
	initial begin
		repeat (10000) @(posedge ref_clk);
		fails++;
		end_sim();
	end

	// Main sequence: boundaries of every operation, writes, random traffic, mid-run reset.
	initial begin
		do_reset();
		cyc(mka(CPSW_OP_ADD, 8'h80, 8'h80, 1'b1), '0, 8'h01);
		cyc(mka(CPSW_OP_ADD, 8'h0f, 8'h01, 1'b0), '0, 8'h03);
		cyc(mka(CPSW_OP_ADD_WITH_CARRY, 8'hff, 8'h00, 1'b1), '0, 8'h07);
		cyc(mka(CPSW_OP_SUBTRACT_WITH_BORROW, 8'h00, 8'h00, 1'b1), '0, 8'h0f);
		cyc(mka(CPSW_OP_SUBTRACT_WITH_BORROW, 8'h80, 8'h01, 1'b0), '0, 8'hff);
		cyc(mka(CPSW_OP_MUL, 8'h0f, 8'h11, 1'b0), '0, 8'h00);
		cyc(mka(CPSW_OP_MUL, 8'h10, 8'h10, 1'b0), '0, 8'h00);
		cyc(mka(CPSW_OP_NONE, 8'h00, 8'h01, 1'b0), '0, 8'h00);
		cyc(mka(CPSW_OP_DIV, 8'h05, 8'h03, 1'b0), '0, 8'h00);
		cyc(mka(CPSW_OP_DIV, 8'h05, 8'h00, 1'b0), '0, 8'h00);
		cyc(mka(CPSW_OP_OTHER_ARITH, 8'h80, 8'h80, 1'b1), '0, 8'h00);
		// Every bit index set and cleared, parity bit included.
		for (int i = 0; i < 16; i++) begin
			cyc('0, mks(1'b0, 1'b1, CPSW_ADDR, 3'(i / 2), 8'h00, ~i[0]), 8'h00);
		end
		// All four bank codes, each also trying to set the parity bit.
		for (int k = 0; k < 4; k++) begin
			cyc('0, mks(1'b1, 1'b0, CPSW_ADDR, 3'h0, {3'h0, 2'(k), 3'h1}, 1'b0), 8'h00);
		end
		cyc('0, mks(1'b1, 1'b0, 8'hd1, 3'h0, 8'hff, 1'b0), 8'h00);
		cyc(mka(CPSW_OP_ADD, 8'h80, 8'h80, 1'b0), mks(1'b1, 1'b0, CPSW_ADDR, 3'h0, 8'h22, 1'b0),
			8'h00);
		// Random traffic, with colliding writes and user flags under arithmetic load.
		for (int n = 0; n < 2000; n++) begin
			r = $random(seed);
			q = $random(seed);
			cyc('{valid: r[0], op: cpsw_op_type'(3'(r[3:1] % 3'h7)), operand_a: q[7:0],
				operand_b: r[4] ? 8'h00 : q[15:8], carry_in: r[5]},
				mks(r[8:6] == 3'h0, r[8:6] == 3'h1, r[9] ? CPSW_ADDR : q[31:24], r[12:10],
				q[23:16], r[13]), r[21:14]);
		end
		cyc('0, '0, 8'h5b);
		cyc('0, '0, 8'h00);
		do_reset();
		cyc('0, '0, 8'h00);
		end_sim();
	end

endmodule : cpu_status_word_flags_bench
